// ---- hw/multiphase_clock_noise_sequence_generator_spread.sv ----
// Multiphase clock generator with down-spread code generation.
//
// How it works
// - Two-phase: all lines half duty, line 2 inverse of line 1.
// - Two-phase: line 3 copies line 1, line 4 copies line 2.
// - Two-phase: output frequency equals divider output frequency.
// - Three-phase: lines 1-3 high one third; line 4 held low.
// - Three-phase: each line lags the previous by a third period.
// - Three-phase: output period is three divider periods.
// - Four-phase: half duty, each line lags previous by quarter period.
// - Four-phase: output period is four divider periods.
// - Pattern select low, mid or high picks two, three or four phases.
// - Slew limiting on for divide by ten or hundred, off for one.
// - Grounded spreading resistor disables spreading, powers down code generation.
// - Nine-bit shift register sequence repeating every 512 shifts.
// - Low seven bits drive the DAC code, updated every shift.
// - Shift register advances once per 3200 master cycles.
// - Zero code gives maximum frequency; full code a one-fifth span.
// - Modulation only ever lowers the frequency.
// - Divider divides master clock by 1, 10 or 100 by ratio select.
// - Sequence generator runs from the master clock, not the outputs.
//
// The clock clk runs at twice the master oscillator rate, so one clk cycle is
// one master half-period and every waveform is built from clock enables.
`timescale 1ns/1ps
`include "clock_spread_defines.svh"
`default_nettype none
module multiphase_clock_noise_sequence_generator_spread #(
    parameter int STEP_CLKS = `STEP_CLKS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] pattern_select_input,
    input wire logic [1:0] ratio_select_input,
    input wire logic spreading_resistor_input,
    output logic clock_line_1,
    output logic clock_line_2,
    output logic clock_line_3,
    output logic clock_line_4,
    output logic slew_limit_en,
    output logic [`DAC_WIDTH-1:0] multiplying_dac_code,
    output logic frequency_spreading,
    output logic code_gen_powered
);
    ////////////////////////////////////////////////////////////////////////////
    // Mode decode.

    clock_spread_pkg::level_type pattern;
    clock_spread_pkg::level_type ratio;
    clock_spread_pkg::level_type pattern_reg;
    logic pattern_changed;
    logic [`PHASE_COUNT_WIDTH-1:0] period;
    logic [`PHASE_COUNT_WIDTH-1:0] high_len;
    logic [`PHASE_COUNT_WIDTH-1:0] spacing;

    assign pattern = clock_spread_pkg::decode_level(pattern_select_input);
    assign ratio = clock_spread_pkg::decode_level(ratio_select_input);
    assign pattern_changed = (pattern != pattern_reg);

    assign period = (pattern == clock_spread_pkg::LEVEL_LOW) ? `PH2_PERIOD :
                    (pattern == clock_spread_pkg::LEVEL_MID) ? `PH3_PERIOD :
                    `PH4_PERIOD;
    assign high_len = (pattern == clock_spread_pkg::LEVEL_LOW) ? `PH2_HIGH :
                      (pattern == clock_spread_pkg::LEVEL_MID) ? `PH3_HIGH :
                      `PH4_HIGH;
    assign spacing = (pattern == clock_spread_pkg::LEVEL_LOW) ? `PH2_SPACING :
                     (pattern == clock_spread_pkg::LEVEL_MID) ? `PH3_SPACING :
                     `PH4_SPACING;

    ////////////////////////////////////////////////////////////////////////////
    // Programmable divider.

    logic tick;

    // Divide by 1, 10 or 100.
    ratio_divider divider (
        .clk(clk),
        .sys_rst(sys_rst),
        .ratio(ratio),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Multiphase generator.

    logic [`PHASE_COUNT_WIDTH-1:0] phase_reg;
    logic [`PHASE_COUNT_WIDTH-1:0] phase_next;
    logic [3:0] lines_next;
    logic [3:0] lines_reg;

    // True when a line with the given offset is high at this point of the cycle.
    function automatic logic line_high(
        input logic [`PHASE_COUNT_WIDTH-1:0] pos,
        input logic [`PHASE_COUNT_WIDTH-1:0] off,
        input logic [`PHASE_COUNT_WIDTH-1:0] per,
        input logic [`PHASE_COUNT_WIDTH-1:0] hi
    );
        logic [`PHASE_COUNT_WIDTH:0] d;
        d = {1'b0, pos} + {1'b0, per} - {1'b0, off};
        if (d >= {1'b0, per}) begin
            d = d - {1'b0, per};
        end
        return d < {1'b0, hi};
    endfunction

    // Pattern change restarts the cycle so no runt phase carries over.
    assign phase_next = pattern_changed ? '0 :
                        !tick ? phase_reg :
                        (phase_reg >= period - 1'b1) ? '0 : phase_reg + 1'b1;

    // Each line is the phase position shifted by its spacing.
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_line
            logic [`PHASE_COUNT_WIDTH-1:0] off_raw;
            logic [`PHASE_COUNT_WIDTH-1:0] off;
            assign off_raw = `PHASE_COUNT_WIDTH'(k * spacing);
            assign off = (off_raw >= period) ? off_raw - period : off_raw;
            if (k == 3) begin : g_last
                // Line 4 idles low in three-phase.
                assign lines_next[k] = (pattern != clock_spread_pkg::LEVEL_MID) &&
                                       line_high(phase_next, off, period, high_len);
            end else begin : g_other
                // Two-phase lines alternate with offsets 0 and 1.
                assign lines_next[k] = line_high(phase_next, off, period, high_len);
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_reg <= '0;
            pattern_reg <= clock_spread_pkg::LEVEL_LOW;
            lines_reg <= 4'h0;
        end else begin
            phase_reg <= phase_next;
            pattern_reg <= pattern;
            lines_reg <= lines_next;
        end
    end

    assign clock_line_1 = lines_reg[0];
    assign clock_line_2 = lines_reg[1];
    assign clock_line_3 = lines_reg[2];
    assign clock_line_4 = lines_reg[3];

    ////////////////////////////////////////////////////////////////////////////
    // Output driver slew control.

    logic slew_reg;

    // Slew limit for divide by ten and hundred.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slew_reg <= 1'b0;
        end else begin
            slew_reg <= (ratio != clock_spread_pkg::LEVEL_LOW);
        end
    end

    assign slew_limit_en = slew_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Spreading code generation.

    spread_if #(.DAC_BITS(`DAC_WIDTH)) spread ();
    logic spreading_reg;
    logic powered_reg;

    assign spread.enable = spreading_resistor_input;

    noise_sequence_generator #(
        .STEP_CLKS(STEP_CLKS)
    ) noise_sequence_generator (
        .clk(clk),
        .sys_rst(sys_rst),
        .link(spread.gen)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spreading_reg <= 1'b0;
            powered_reg <= 1'b0;
        end else begin
            spreading_reg <= spread.enable && spread.powered;
            powered_reg <= spread.powered;
        end
    end

    // Code only adds pull-down depth; zero is full speed.
    assign multiplying_dac_code = spread.code;
    assign frequency_spreading = spreading_reg;
    assign code_gen_powered = powered_reg;
endmodule
`default_nettype wire

// ---- inc/clock_spread_defines.svh ----
// Constants for the multiphase clock and spreading code block.
`ifndef CLOCK_SPREAD_DEFINES_SVH
`define CLOCK_SPREAD_DEFINES_SVH

// Clock cycles per master oscillator period; clk is twice the master rate.
`define CLK_PER_MASTER 2
// Master oscillator periods per spreading code step.
`define MASTER_STEP_CYCLES 3200
`define STEP_CLKS (`MASTER_STEP_CYCLES * `CLK_PER_MASTER)

// Divider ratios, held as terminal counts of the half-period counter.
`define DIV_LAST_N1 7'd0
`define DIV_LAST_N10 7'd9
`define DIV_LAST_N100 7'd99
`define DIV_COUNT_WIDTH 7

// Multiphase periods, high lengths and phase spacing, in divider half-periods.
`define PHASE_COUNT_WIDTH 4
`define PH2_PERIOD 4'd2
`define PH2_HIGH 4'd1
`define PH2_SPACING 4'd1
`define PH3_PERIOD 4'd6
`define PH3_HIGH 4'd2
`define PH3_SPACING 4'd2
`define PH4_PERIOD 4'd8
`define PH4_HIGH 4'd4
`define PH4_SPACING 4'd2

// Noise sequence generator.
`define LFSR_WIDTH 9
`define LFSR_SEED 9'h001
`define DAC_WIDTH 7

`endif

// ---- inc/clock_spread_pkg.sv ----
// Types shared by the multiphase clock and spreading code block.
`default_nettype none
package clock_spread_pkg;

    typedef enum logic [1:0] {
        LEVEL_LOW = 2'b00,
        LEVEL_MID = 2'b01,
        LEVEL_HIGH = 2'b11
    } level_type;

    typedef enum logic [1:0] {
        SPREAD_OFF = 2'b00,
        SPREAD_SEED = 2'b01,
        SPREAD_RUN = 2'b11
    } spread_state_type;

    // A three-level pin arrives as 00 low, 01 mid, 11 high; 10 counts as floating.
    function automatic level_type decode_level(input logic [1:0] pin);
        level_type lvl;
        lvl = LEVEL_MID;
        if (pin == 2'b00) begin
            lvl = LEVEL_LOW;
        end else if (pin == 2'b11) begin
            lvl = LEVEL_HIGH;
        end
        return lvl;
    endfunction

endpackage
`default_nettype wire

// ---- inc/spread_if.sv ----
// Link between the top module and the noise sequence generator.
`timescale 1ns/1ps
`default_nettype none
interface spread_if #(
    parameter int DAC_BITS = 7
);
    logic enable;
    logic powered;
    logic step;
    logic [DAC_BITS-1:0] code;

    modport gen (
        input enable,
        output powered,
        output step,
        output code
    );

    modport user (
        output enable,
        input powered,
        input step,
        input code
    );
endinterface
`default_nettype wire

// ---- hw/ratio_divider.sv ----
// Programmable divider: one tick per divider output half-period.
`timescale 1ns/1ps
`include "clock_spread_defines.svh"
`default_nettype none
module ratio_divider (
    input wire logic clk,
    input wire logic sys_rst,
    input wire clock_spread_pkg::level_type ratio,
    output logic tick
);
    logic [`DIV_COUNT_WIDTH-1:0] count_reg;
    logic [`DIV_COUNT_WIDTH-1:0] count_next;
    logic [`DIV_COUNT_WIDTH-1:0] last_count;
    clock_spread_pkg::level_type ratio_reg;
    logic ratio_changed;
    logic at_last;

    assign last_count = (ratio == clock_spread_pkg::LEVEL_LOW) ? `DIV_LAST_N1 :
                        (ratio == clock_spread_pkg::LEVEL_MID) ? `DIV_LAST_N10 :
                        `DIV_LAST_N100;
    assign ratio_changed = (ratio != ratio_reg);
    assign at_last = (count_reg >= last_count);
    assign tick = at_last && !ratio_changed;
    assign count_next = (at_last || ratio_changed) ? '0 : count_reg + 1'b1;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_reg <= '0;
            ratio_reg <= clock_spread_pkg::LEVEL_LOW;
        end else begin
            count_reg <= count_next;
            ratio_reg <= ratio;
        end
    end
endmodule
`default_nettype wire

// ---- hw/noise_sequence_generator.sv ----
// Nine-bit shift register sequence feeding the multiplying DAC code.
`timescale 1ns/1ps
`include "clock_spread_defines.svh"
`default_nettype none
module noise_sequence_generator #(
    parameter int STEP_CLKS = `STEP_CLKS
) (
    input wire logic clk,
    input wire logic sys_rst,
    spread_if.gen link
);
    localparam int PW = $clog2(STEP_CLKS);

    clock_spread_pkg::spread_state_type state_reg;
    clock_spread_pkg::spread_state_type state_next;
    logic [PW-1:0] pre_reg;
    logic [`LFSR_WIDTH-1:0] lfsr_reg;
    logic [`LFSR_WIDTH-1:0] lfsr_next;
    logic [`DAC_WIDTH-1:0] code_reg;
    logic step_reg;
    logic pre_done;
    logic feedback;

    // Taps 9 and 5 with the low-bits-zero term: a 512-state walk through every code.
    assign feedback = lfsr_reg[8] ^ lfsr_reg[4] ^ (lfsr_reg[7:0] == 8'h00);
    assign lfsr_next = {lfsr_reg[7:0], feedback};
    assign pre_done = (pre_reg == PW'(STEP_CLKS - 1));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            clock_spread_pkg::SPREAD_OFF: begin
                if (link.enable) begin
                    state_next = clock_spread_pkg::SPREAD_SEED;
                end
            end
            clock_spread_pkg::SPREAD_SEED: begin
                state_next = link.enable ? clock_spread_pkg::SPREAD_RUN
                                         : clock_spread_pkg::SPREAD_OFF;
            end
            clock_spread_pkg::SPREAD_RUN: begin
                if (!link.enable) begin
                    state_next = clock_spread_pkg::SPREAD_OFF;
                end
            end
            default: begin
                state_next = clock_spread_pkg::SPREAD_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= clock_spread_pkg::SPREAD_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Prescaler counts clk, which runs locked to the master oscillator.
    // One shift per 3200 master periods.
    always_ff @(posedge clk) begin
        if (sys_rst || state_reg != clock_spread_pkg::SPREAD_RUN) begin
            pre_reg <= '0;
        end else if (pre_done) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || state_reg != clock_spread_pkg::SPREAD_RUN) begin
            lfsr_reg <= `LFSR_SEED;
        end else if (pre_done) begin
            lfsr_reg <= lfsr_next;
        end
    end

    // Low seven bits become the DAC code each shift.
    // Code held at zero while powered down.
    always_ff @(posedge clk) begin
        if (sys_rst || state_reg == clock_spread_pkg::SPREAD_OFF || !link.enable) begin
            code_reg <= '0;
        end else if (state_reg == clock_spread_pkg::SPREAD_SEED) begin
            code_reg <= lfsr_reg[`DAC_WIDTH-1:0];
        end else if (pre_done) begin
            code_reg <= lfsr_next[`DAC_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            step_reg <= 1'b0;
        end else begin
            step_reg <= (state_reg == clock_spread_pkg::SPREAD_RUN) && pre_done && link.enable;
        end
    end

    assign link.code = code_reg;
    assign link.step = step_reg;
    assign link.powered = (state_reg != clock_spread_pkg::SPREAD_OFF);
endmodule
`default_nettype wire

// ---- test/clock_load.sv ----
// Clocked load model that counts rising edges on one clock line.
`timescale 1ns/1ps
`default_nettype none
module clock_load (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic line_in,
    output logic [15:0] rise_count_reg
);
    logic prev_reg;
    wire rise = line_in && !prev_reg;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_reg <= 1'b0;
            rise_count_reg <= 16'h0000;
        end else begin
            prev_reg <= line_in;
            rise_count_reg <= rise_count_reg + {15'h0000, rise};
        end
    end
endmodule
`default_nettype wire

// ---- test/clock_spread_props.sv ----
// Concurrent checks on the ports of the multiphase clock block.
`timescale 1ns/1ps
`include "clock_spread_defines.svh"
`default_nettype none
module clock_spread_props #(
    parameter int STEP_CLKS = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] pattern_select_input,
    input wire logic [1:0] ratio_select_input,
    input wire logic spreading_resistor_input,
    input wire logic clock_line_1,
    input wire logic clock_line_2,
    input wire logic clock_line_3,
    input wire logic clock_line_4,
    input wire logic slew_limit_en,
    input wire logic [`DAC_WIDTH-1:0] multiplying_dac_code,
    input wire logic frequency_spreading,
    input wire logic code_gen_powered
);
    logic [7:0] settle_reg;
    logic [7:0] settle_next;
    logic [1:0] pat_reg;
    logic [1:0] rat_reg;
    // Waveform checks only hold once both selects sat still for a while.
    wire same = pattern_select_input == pat_reg && ratio_select_input == rat_reg;
    wire ok = same && settle_reg == 8'hff;
    // A select change abandons any multi-cycle waveform check still in flight.
    wire unsettled = sys_rst || !same;
    wire p_low = pattern_select_input == 2'b00;
    wire p_high = pattern_select_input == 2'b11;
    wire p_mid = !p_low && !p_high;
    wire div1 = ratio_select_input == 2'b00;
    wire div10 = !div1 && ratio_select_input != 2'b11;
    assign settle_next = (!same || sys_rst) ? 8'h00 : settle_reg + {7'h00, settle_reg != 8'hff};
    always_ff @(posedge clk) begin
        pat_reg <= pattern_select_input;
        rat_reg <= ratio_select_input;
        settle_reg <= settle_next;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_lag;
        ##2 $rose(clock_line_2) ##2 $rose(clock_line_3);
    endsequence
    sequence s_three;
        clock_line_1 [*2] ##1 !clock_line_1 [*4] ##1 clock_line_1;
    endsequence
    sequence s_four;
        clock_line_1 [*4] ##1 !clock_line_1 [*4] ##1 clock_line_1;
    endsequence
    inverse_lines_a: assert property (ok && p_low |-> clock_line_2 == !clock_line_1)
        else $error("line 2 not inverse of line 1");
    copy_lines_a: assert property (ok && p_low |->
        clock_line_3 == clock_line_1 && clock_line_4 == clock_line_2)
        else $error("lines 3 and 4 not copies");
    line4_low_a: assert property (ok && p_mid |-> !clock_line_4)
        else $error("line 4 active in three phase");
    three_lag_a: assert property (disable iff (unsettled)
        ok && p_mid && div1 && $rose(clock_line_1) |-> s_lag)
        else $error("three phase lag wrong");
    three_period_a: assert property (disable iff (unsettled)
        ok && p_mid && div1 && $rose(clock_line_1) |-> s_three)
        else $error("three phase period wrong");
    four_lag_a: assert property (disable iff (unsettled)
        ok && p_high && div1 && $rose(clock_line_1) |-> s_lag ##2 $rose(clock_line_4))
        else $error("four phase lag wrong");
    four_period_a: assert property (disable iff (unsettled)
        ok && p_high && div1 && $rose(clock_line_1) |-> s_four)
        else $error("four phase period wrong");
    two_period_a: assert property (disable iff (unsettled)
        ok && p_low && div10 && $rose(clock_line_1) |->
        ##9 clock_line_1 ##1 !clock_line_1 ##9 !clock_line_1 ##1 clock_line_1)
        else $error("two phase period wrong");
    slew_ratio_a: assert property (!sys_rst |=>
        slew_limit_en == ($past(ratio_select_input) != 2'b00))
        else $error("slew limit wrong for ratio");
    spread_off_a: assert property (!spreading_resistor_input |->
        ##[1:2] (multiplying_dac_code == 7'h00 && !frequency_spreading))
        else $error("spreading not off");
endmodule
bind multiphase_clock_noise_sequence_generator_spread clock_spread_props #(.STEP_CLKS(STEP_CLKS)) i_props (
    .clk(clk), .sys_rst(sys_rst), .pattern_select_input(pattern_select_input),
    .ratio_select_input(ratio_select_input), .spreading_resistor_input(spreading_resistor_input),
    .clock_line_1(clock_line_1), .clock_line_2(clock_line_2), .clock_line_3(clock_line_3),
    .clock_line_4(clock_line_4), .slew_limit_en(slew_limit_en),
    .multiplying_dac_code(multiplying_dac_code), .frequency_spreading(frequency_spreading),
    .code_gen_powered(code_gen_powered));
`default_nettype wire

// ---- test/multiphase_clock_noise_sequence_generator_spread_tb.sv ----
// Self-checking bench for the multiphase clock and spreading code block.
`timescale 1ns/1ps
`include "clock_spread_defines.svh"
`default_nettype none
module multiphase_clock_noise_sequence_generator_spread_tb;
    localparam int STEP = 16;
    logic clk, sys_rst, sri, l1, l2, l3, l4, slew, fs, pwr;
    logic [1:0] pat, rat;
    logic [`DAC_WIDTH-1:0] code;
    logic [15:0] rises;
    logic [8:0] q;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    multiphase_clock_noise_sequence_generator_spread #(.STEP_CLKS(STEP)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .pattern_select_input(pat), .ratio_select_input(rat), .spreading_resistor_input(sri),
        .clock_line_1(l1), .clock_line_2(l2), .clock_line_3(l3), .clock_line_4(l4),
        .slew_limit_en(slew), .multiplying_dac_code(code), .frequency_spreading(fs),
        .code_gen_powered(pwr));
    clock_load i_load (.clk(clk), .sys_rst(sys_rst), .line_in(l4), .rise_count_reg(rises));
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Each tick of the divider moves the pattern one nibble along exp.
    task automatic run_phase(input logic [1:0] p, input logic [1:0] r, input int n,
            input int len, input logic [31:0] exp);
        logic [15:0] r0;
        int k;
        @(posedge clk);
        pat <= p;
        rat <= r;
        step(300);
        for (k = 0; k < 1000 && l1 !== 1'b0; k++) step(1);
        for (k = 0; k < 1000 && l1 !== 1'b1; k++) step(1);
        r0 = rises;
        for (k = 0; k < 2 * len; k++) begin
            check(16'({l4, l3, l2, l1}), 16'(exp[4 * (k % len) +: 4]));
            step(n);
        end
        check(rises - r0, (p == 2'b00 || p == 2'b11) ? 16'h0002 : 16'h0000);
        step(n * len + 4);
        $display("phase test done");
    endtask
    task automatic slew_test();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            rat <= 2'(i);
            step(2);
            check(16'(slew), 16'(i != 0));
        end
        $display("slew test done");
    endtask
    task automatic spread_test();
        int k;
        @(posedge clk);
        pat <= 2'b11;
        rat <= 2'b11;
        sri <= 1'b1;
        for (k = 0; k < 20 && code !== 7'h01; k++) step(1);
        check(16'(code), 16'h0001);
        step(2);
        check(16'({fs, pwr}), 16'h0003);
        for (k = 0; k < 2 * STEP && code === 7'h01; k++) step(1);
        q = 9'h001;
        for (k = 0; k < 511; k++) begin
            q = {q[7:0], q[8] ^ q[4] ^ (q[7:0] == 8'h00)};
            check(16'(code), 16'(q[6:0]));
            step(STEP);
        end
        check(16'(code), 16'h0001);
        @(posedge clk);
        sri <= 1'b0;
        step(3);
        check(16'({code, fs, pwr}), 16'h0000);
        @(posedge clk);
        sri <= 1'b1;
        for (k = 0; k < 20 && code !== 7'h01; k++) step(1);
        check(16'(code), 16'h0001);
        $display("spread test done");
    endtask
    task automatic reset_test();
        @(posedge clk);
        sys_rst <= 1'b1;
        step(2);
        check(16'({l1, l2, l3, l4, slew, fs, pwr, code}), 16'h0000);
        @(posedge clk);
        sys_rst <= 1'b0;
        step(2);
        check(16'(code), 16'h0001);
        check(16'({l4, l3, l2, l1, slew}), 16'h0013);
        $display("reset test done");
    endtask
    initial begin
        sys_rst = 1'b1;
        pat = 2'b00;
        rat = 2'b00;
        sri = 1'b0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        run_phase(2'b00, 2'b00, 1, 2, 32'h0000_00a5);
        run_phase(2'b00, 2'b01, 10, 2, 32'h0000_00a5);
        run_phase(2'b00, 2'b11, 100, 2, 32'h0000_00a5);
        run_phase(2'b01, 2'b00, 1, 6, 32'h0044_2211);
        run_phase(2'b10, 2'b10, 10, 6, 32'h0044_2211);
        run_phase(2'b11, 2'b00, 1, 8, 32'hcc66_3399);
        run_phase(2'b11, 2'b01, 10, 8, 32'hcc66_3399);
        slew_test();
        spread_test();
        reset_test();
        stop_test();
    end
endmodule
`default_nettype wire
